// file: design/bie_cfg.svh
// ============================================================
// Constants of the error log and identity register bank
// Assumes one 20 MHz clock and registers reached by index
`ifndef BIE_CFG_SVH
`define BIE_CFG_SVH
// Register indices
`define BIE_OFS_ERR_LOG     5'h00
`define BIE_OFS_DEV_TYPE    5'h01
`define BIE_OFS_DEV_ID      5'h02
`define BIE_OFS_LOGICAL_IDENTITY_REGISTER  5'h03
`define BIE_OFS_RCV_CTRL    5'h10
`define BIE_OFS_BUS_XCHG    5'h1D
// Error log fields
`define BIE_LOG_TYPE_LSB    12
`define BIE_LOG_BUS_LSB     9
`define BIE_LOG_MOD_LSB     3
`define BIE_LOG_PERM_BIT    2
`define BIE_LOG_TALLY_LSB   0
// Device type fields
`define BIE_TYP_BOARD_LSB   11
`define BIE_TYP_PROC_LSB    8
`define BIE_TYP_VER_LSB     4
`define BIE_TYP_F_BIT       3
`define BIE_TYP_DEV_LSB     0
// Device identity fields
`define BIE_ID_BUS_LSB      8
`define BIE_ID_MOD_LSB      0
// Processor bus load positions
`define BIE_ACD_PARITY_BIT  1
`define BIE_ACD_PROC_LSB    3
`define BIE_ACD_BOARD_LSB   6
`define BIE_ACD_MOD_LSB     8
// Control bits and reset values
`define BIE_CTRL_BUS_EN     0
`define BIE_CTRL_MOD_EN     1
`define BIE_CTRL_SHADOW     2
`define BIE_RCV_CTRL_RESET  3'h0
// Timing
`define BIE_CLK_PERIOD_NS   50
`define BIE_ERR_WINDOW_NS   3200
`define BIE_ERR_WINDOW_CYC  (`BIE_ERR_WINDOW_NS / `BIE_CLK_PERIOD_NS)
`endif

// file: design/bie_pkg.sv
// ============================================================
// Types of the error log and identity register bank
// Assumes nothing beyond the constants header
package bie_pkg;
  // Report type codes
  typedef enum logic [3:0] {
    BIE_T_TOGGLE  = 4'h0, BIE_T_DETACH   = 4'h1, BIE_T_ATTACH  = 4'h2,
    BIE_T_XCHG    = 4'h3, BIE_T_TEST     = 4'h4, BIE_T_CECC    = 4'h5,
    BIE_T_UECC    = 4'h6, BIE_T_BMLOW    = 4'h7, BIE_T_BPAR    = 4'h8,
    BIE_T_MODULE  = 4'h9, BIE_T_NOERR    = 4'hA, BIE_T_BMHIGH  = 4'hB,
    BIE_T_ARB     = 4'hC, BIE_T_UNSAFE   = 4'hD, BIE_T_MERLPAR = 4'hE,
    BIE_T_BERLPAR = 4'hF
  } bie_err_type_t;
  // Recovery actions
  typedef enum {
    BIE_A_NONE, BIE_A_RETRY, BIE_A_RETRY_STAGE, BIE_A_ATTACH, BIE_A_DETACH,
    BIE_A_BUS_SW, BIE_A_MOD_SW, BIE_A_BUS_OR_MOD
  } bie_action_t;
endpackage

// file: design/bie_regs.sv
// ============================================================
// Error log, classification, recovery and identity registers
// Assumes error reports arrive decoded on the local clock and
// that processor bus, init and bus identity pins are asynchronous
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ns
`include "bie_cfg.svh"

module bie_regs
  import bie_pkg::*;
#(
  parameter int          WINDOW_CYCLES = `BIE_ERR_WINDOW_CYC,
  parameter logic [2:0]  DEVICE_TYPE   = 3'h5, // Arbitrary value
  parameter logic [1:0]  DEVICE_VER    = 2'h0  // Arbitrary value
) (
  // Clock and reset
  input  wire logic        I_REF_CLK,
  input  wire logic        I_RESETN,
  // Register port
  input  wire logic [4:0]  I_ADDR,
  input  wire logic [15:0] I_WDATA,
  input  wire logic        I_WR,
  input  wire logic        I_RD,
  output logic      [15:0] O_RDATA,
  // Initialization pins
  input  wire logic        I_INIT,
  input  wire logic [15:0] I_ACD,
  input  wire logic [2:0]  I_BUS_ID,
  // Error reports
  input  wire logic        I_ERR_VALID,
  input  wire logic [3:0]  I_ERR_TYPE,
  input  wire logic [2:0]  I_ERR_BUS,
  input  wire logic [5:0]  I_ERR_MOD,
  // Recovery actions
  output logic             O_RETRY,
  output logic             O_STAGE,
  output logic             O_ATTACH,
  output logic             O_DETACH,
  output logic             O_BUS_SWITCH,
  output logic             O_MODULE_SWITCH,
  // Identity and status
  output logic             O_INIT_INTERNAL,
  output logic             O_BUFFER_CHECK,
  output logic [5:0]       O_ARB_PRIORITY,
  output logic [5:0]       O_PARTICIPATE_ID,
  output logic [2:0]       O_BACKUP_BUS_ID
);

  localparam int CW = $clog2(WINDOW_CYCLES + 1);

  // Refuse a window that the counter cannot serve
  if (WINDOW_CYCLES < 1) begin : g_bad_window
    $error("WINDOW_CYCLES must be at least one");
  end

  // Recovery action for a type code and its permanence
  function automatic bie_action_t decode_action(input logic [3:0] t, input logic p);
    bie_err_type_t et;
    et = bie_err_type_t'(t);
    decode_action = BIE_A_NONE;
    if (p) begin
      case (et)
        BIE_T_BERLPAR, BIE_T_ARB, BIE_T_BPAR:                   decode_action = BIE_A_BUS_SW;
        BIE_T_MERLPAR, BIE_T_UNSAFE, BIE_T_MODULE, BIE_T_UECC: decode_action = BIE_A_MOD_SW;
        BIE_T_BMHIGH, BIE_T_BMLOW:                             decode_action = BIE_A_BUS_OR_MOD;
        default:                                               decode_action = BIE_A_NONE;
      endcase
    end else begin
      case (et)
        BIE_T_BERLPAR, BIE_T_MERLPAR, BIE_T_ARB, BIE_T_BMHIGH,
        BIE_T_MODULE, BIE_T_BPAR, BIE_T_BMLOW:                 decode_action = BIE_A_RETRY;
        BIE_T_UECC, BIE_T_CECC:                                decode_action = BIE_A_RETRY_STAGE;
        BIE_T_ATTACH:                                          decode_action = BIE_A_ATTACH;
        BIE_T_DETACH:                                          decode_action = BIE_A_DETACH;
        default:                                               decode_action = BIE_A_NONE;
      endcase
    end
  endfunction

  // ============================================================
  // Pin synchronisers
  logic [1:0]  init_sync;
  logic [15:0] acd_meta;
  logic [15:0] acd_s;
  logic [2:0]  bus_meta;
  logic [2:0]  bus_s;
  logic        init_s;

  // Two flip-flops on every asynchronous pin
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RESETN) begin
      init_sync <= 2'h0;
      acd_meta  <= 16'h0000;
      acd_s     <= 16'h0000;
      bus_meta  <= 3'h0;
      bus_s     <= 3'h0;
    end else begin
      init_sync <= {init_sync[0], I_INIT};
      acd_meta  <= I_ACD;
      acd_s     <= acd_meta;
      bus_meta  <= I_BUS_ID;
      bus_s     <= bus_meta;
    end
  end
  assign init_s = init_sync[1];

  // ============================================================
  // Identity registers
  logic [2:0] proc_type;
  logic [1:0] board_type;
  logic [5:0] module_id;
  logic       id_parity;
  logic       id_loaded;
  logic       parity_hold;
  logic [5:0] logical_identity_register;
  logic [2:0] rcv_ctrl;
  logic       wr_logical;
  logic       wr_ctrl;
  logic       wr_xchg;

  assign wr_logical = I_WR && (I_ADDR == `BIE_OFS_LOGICAL_IDENTITY_REGISTER);
  assign wr_ctrl    = I_WR && (I_ADDR == `BIE_OFS_RCV_CTRL);
  assign wr_xchg    = I_WR && (I_ADDR == `BIE_OFS_BUS_XCHG);

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RESETN) begin
      proc_type  <= 3'h0;
      board_type <= 2'h0;
      module_id  <= 6'h00;
      id_parity  <= 1'b0;
      id_loaded  <= 1'b0;
    end else if (init_s) begin
      proc_type  <= acd_s[`BIE_ACD_PROC_LSB +: 3];
      board_type <= acd_s[`BIE_ACD_BOARD_LSB +: 2];
      module_id  <= acd_s[`BIE_ACD_MOD_LSB +: 6];
      id_parity  <= acd_s[`BIE_ACD_PARITY_BIT];
      id_loaded  <= 1'b1;
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RESETN) begin
      parity_hold <= 1'b0;
    end else if (id_loaded && !init_s && (^{module_id, id_parity})) begin
      parity_hold <= 1'b1;
    end
  end
  // Bad parity raises internal init at once, so there is no gap when init drops
  assign O_INIT_INTERNAL = init_s | parity_hold | (id_loaded & (^{module_id, id_parity}));

  // only the writable logical field takes writes
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RESETN) begin
      logical_identity_register <= 6'h00;
    end else if (init_s) begin
      logical_identity_register <= {acd_s[`BIE_ACD_MOD_LSB], acd_s[`BIE_ACD_MOD_LSB+1],
                     acd_s[`BIE_ACD_MOD_LSB+2], acd_s[`BIE_ACD_MOD_LSB+3],
                     acd_s[`BIE_ACD_MOD_LSB+4], acd_s[`BIE_ACD_MOD_LSB+5]};
    end else if (wr_logical) begin
      logical_identity_register <= I_WDATA[5:0];
    end
  end

  // Recovery enables and shadow mode
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RESETN) begin
      rcv_ctrl <= `BIE_RCV_CTRL_RESET;
    end else if (wr_ctrl) begin
      rcv_ctrl <= I_WDATA[2:0];
    end
  end

  assign O_ARB_PRIORITY   = logical_identity_register;
  assign O_PARTICIPATE_ID = rcv_ctrl[`BIE_CTRL_SHADOW] ? logical_identity_register : module_id;
  assign O_BACKUP_BUS_ID  = {bus_s[2], ~bus_s[1], bus_s[0]};

  // buffer check toggles only outside initialize
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RESETN) begin
      O_BUFFER_CHECK <= 1'b0;
    end else if (!O_INIT_INTERNAL && board_type[0]) begin
      O_BUFFER_CHECK <= ~O_BUFFER_CHECK;
    end
  end

  // ============================================================
  // Error classification and log
  logic [3:0]    log_type;
  logic [2:0]    log_bus;
  logic [5:0]    log_mod;
  logic          log_perm;
  logic [1:0]    tally;
  logic [CW-1:0] win_cnt;
  logic          win_open;
  logic          report;
  logic          perm_now;
  logic          bus_sw_done;
  bie_action_t   act;

  assign report   = I_ERR_VALID && !init_s;
  assign win_open = (win_cnt != '0);
  assign perm_now = (I_ERR_TYPE == BIE_T_UNSAFE) ||
                    (win_open && (I_ERR_TYPE == log_type) && (I_ERR_MOD == log_mod));
  assign act      = decode_action(I_ERR_TYPE, perm_now);

  // init clears tally and permanence only
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RESETN) begin
      log_type <= 4'h0;
      log_bus  <= 3'h0;
      log_mod  <= 6'h00;
      log_perm <= 1'b0;
      tally    <= 2'h0;
    end else if (init_s) begin
      log_perm <= 1'b0;
      tally    <= 2'h0;
    end else if (report) begin
      log_type <= I_ERR_TYPE;
      log_bus  <= I_ERR_BUS;
      log_mod  <= I_ERR_MOD;
      log_perm <= perm_now;
      tally    <= (tally == 2'h3) ? 2'h3 : tally + 2'h1;
    end else if (wr_xchg) begin
      tally    <= 2'h0;
    end
  end

  // window reopens after a bus switch
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RESETN || init_s) begin
      win_cnt <= '0;
    end else if (report || bus_sw_done) begin
      win_cnt <= CW'(WINDOW_CYCLES);
    end else if (win_open) begin
      win_cnt <= win_cnt - CW'(1);
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RESETN) begin
      O_RETRY         <= 1'b0;
      O_STAGE         <= 1'b0;
      O_ATTACH        <= 1'b0;
      O_DETACH        <= 1'b0;
      O_BUS_SWITCH    <= 1'b0;
      O_MODULE_SWITCH <= 1'b0;
    end else begin
      O_RETRY         <= report || O_BUS_SWITCH;
      O_STAGE         <= report && (act == BIE_A_RETRY_STAGE);
      O_ATTACH        <= report && (act == BIE_A_ATTACH);
      O_DETACH        <= report && (act == BIE_A_DETACH);
      O_BUS_SWITCH    <= report && rcv_ctrl[`BIE_CTRL_BUS_EN] &&
                         ((act == BIE_A_BUS_SW) || (act == BIE_A_BUS_OR_MOD));
      O_MODULE_SWITCH <= report && rcv_ctrl[`BIE_CTRL_MOD_EN] &&
                         ((act == BIE_A_MOD_SW) ||
                          ((act == BIE_A_BUS_OR_MOD) && !rcv_ctrl[`BIE_CTRL_BUS_EN]));
    end
  end
  assign bus_sw_done = O_BUS_SWITCH;

  // ============================================================
  // Register read port
  // fixed type fields
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RESETN || !I_RD) begin
      O_RDATA <= 16'h0000;
    end else begin
      case (I_ADDR)
        `BIE_OFS_ERR_LOG:    O_RDATA <= {log_type, log_bus, log_mod, log_perm, tally};
        `BIE_OFS_DEV_TYPE:   O_RDATA <= {3'h0, board_type, proc_type, 2'h0,
                                         DEVICE_VER, 1'b1, DEVICE_TYPE};
        `BIE_OFS_DEV_ID:     O_RDATA <= {5'h00, bus_s, 2'h0, module_id};
        `BIE_OFS_LOGICAL_IDENTITY_REGISTER: O_RDATA <= {10'h000, logical_identity_register};
        `BIE_OFS_RCV_CTRL:   O_RDATA <= {13'h0000, rcv_ctrl};
        default:             O_RDATA <= 16'h0000;
      endcase
    end
  end

  // ============================================================
  // Assertions
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RESETN);

  a_retry_follows: assert property (report |=> O_RETRY)
    else $error("Report not followed by retry");
  a_unsafe_perm: assert property (report && I_ERR_TYPE == 4'hD |=> log_perm)
    else $error("Unsafe module not permanent");
  a_first_trans: assert property (report && !win_open && I_ERR_TYPE != 4'hD |=> !log_perm)
    else $error("First report not transient");
  a_repeat_perm: assert property (report && win_open && I_ERR_TYPE == log_type
                                  && I_ERR_MOD == log_mod |=> log_perm)
    else $error("Repeat not permanent");
  a_switch_retry: assert property (O_BUS_SWITCH |=> O_RETRY && win_cnt == CW'(WINDOW_CYCLES))
    else $error("Bus switch without retry and window");
  a_switch_gate: assert property (O_BUS_SWITCH |-> $past(rcv_ctrl[0]))
    else $error("Bus switch while disabled");
  a_tally_sat: assert property (tally == 2'h3 && !init_s && !wr_xchg |=> tally == 2'h3)
    else $error("Tally left saturation");
  a_init_clear: assert property (init_s |=> tally == 2'h0 && !log_perm
                                 && $stable(log_type) && $stable(log_mod))
    else $error("Init handling of log wrong");
  a_buffer_check_output_stop: assert property (O_INIT_INTERNAL |=> $stable(O_BUFFER_CHECK))
    else $error("Buffer check toggled in init");
  a_parity_hold: assert property (id_loaded && (^{module_id, id_parity}) |-> O_INIT_INTERNAL)
    else $error("Internal init dropped");
  a_backup_bus: assert property (O_BACKUP_BUS_ID[1] != bus_s[1])
    else $error("Backup bus middle bit not inverted");
  a_type_fixed: assert property (I_RD && I_ADDR == 5'h01 |=> O_RDATA[3] == 1'b1)
    else $error("Constant one field wrong");

  c_bus_switch: cover property (report ##1 O_BUS_SWITCH ##1 O_RETRY);
  c_perm_repeat: cover property (report && !perm_now ##[1:20] report && perm_now);
  c_stage: cover property (O_STAGE);
  c_tally_full: cover property (tally == 2'h3);

endmodule

// file: bench/bie_reporter.sv
// ============================================================
// Far-side model: an agent raising reports on the error lines
// Assumes send is called just after a rising edge of i_clk
`timescale 1ns/1ns

module bie_reporter (
  // Clock
  input  wire logic       i_clk,
  // Report lines
  output logic            o_valid,
  output logic [3:0]      o_type,
  output logic [2:0]      o_bus,
  output logic [5:0]      o_mod
);
  // Idle lines at time zero
  initial begin
    o_valid = 1'b0;
    o_type  = 4'h0;
    o_bus   = 3'h0;
    o_mod   = 6'h00;
  end

  // One-cycle report; released fields show the inverse, not a stale copy
  task automatic send(input logic [3:0] t, input logic [2:0] b, input logic [5:0] m);
    o_valid <= 1'b1;
    o_type  <= t;
    o_bus   <= b;
    o_mod   <= m;
    @(posedge i_clk);
    o_valid <= 1'b0;
    o_type  <= ~t;
    o_bus   <= ~b;
    o_mod   <= ~m;
  endtask
endmodule

// file: bench/bie_regs_test.sv
// ============================================================
// Self-checking bench of the error log and identity registers
// Assumes a 20 MHz clock and a shortened window of WIN cycles
`timescale 1ns/1ns
`include "bie_cfg.svh"

module bie_regs_test;
  localparam int         WIN  = 8;
  localparam logic [2:0] DTYP = 3'h6;  // Arbitrary value
  localparam logic [1:0] DVER = 2'h2;  // Arbitrary value
  localparam logic [5:0] MOD  = 6'h26;
  localparam logic [5:0] RMOD = 6'h19; // MOD bit-reversed
  localparam logic [2:0] BUS  = 3'h4;
  localparam logic [2:0] PROC = 3'h5;
  localparam logic [1:0] BRD  = 2'h3;
  localparam logic [5:0] SRC  = 6'h0A;
  localparam logic [15:0] ACD = {2'h0, MOD, BRD, PROC, 3'h2}; // Even parity bit set

  logic        clk, rstn, wr, rd, init;
  logic [4:0]  addr;
  logic [15:0] wdata, acd;
  logic [2:0]  bus_id, ebus;
  logic [15:0] rdata;
  logic [3:0]  etype;
  logic [5:0]  emod, arb, part;
  logic        ev, retry, stage, att, det, bsw, msw, iint, bchk;
  logic [2:0]  bkup;
  logic        b0;
  int          num_errors, check_count, tally;
  logic [3:0]  pc [8] = '{4'hF, 4'hE, 4'hC, 4'hB, 4'h9, 4'h8, 4'h7, 4'h6};

  // ============================================================
  // Design, far side and clock
  bie_regs #(.WINDOW_CYCLES(WIN), .DEVICE_TYPE(DTYP), .DEVICE_VER(DVER)) u_dut (
    .I_REF_CLK(clk), .I_RESETN(rstn), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
    .I_RD(rd), .O_RDATA(rdata), .I_INIT(init), .I_ACD(acd), .I_BUS_ID(bus_id),
    .I_ERR_VALID(ev), .I_ERR_TYPE(etype), .I_ERR_BUS(ebus), .I_ERR_MOD(emod),
    .O_RETRY(retry), .O_STAGE(stage), .O_ATTACH(att), .O_DETACH(det),
    .O_BUS_SWITCH(bsw), .O_MODULE_SWITCH(msw), .O_INIT_INTERNAL(iint),
    .O_BUFFER_CHECK(bchk), .O_ARB_PRIORITY(arb), .O_PARTICIPATE_ID(part),
    .O_BACKUP_BUS_ID(bkup));
  bie_reporter u_rep (.i_clk(clk), .o_valid(ev), .o_type(etype), .o_bus(ebus), .o_mod(emod));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ============================================================
  // Access and compare tasks
  task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr    <= 1'b0;
    // Idle edge, so a following call never assigns the strobe twice at once
    @(posedge clk);
  endtask
  task automatic rd_reg(input string n, input logic [4:0] a, input logic [15:0] exp);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    chk(n, rdata, exp);
  endtask
  // Transient action set {retry,stage,attach,detach,bus sw,module sw}
  function automatic logic [5:0] tact(input logic [3:0] c);
    return {1'b1, (c == 4'h5) || (c == 4'h6), c == 4'h2, c == 4'h1, 2'b00};
  endfunction
  // Report, check actions, later retry and the log
  task automatic rep(input logic [3:0] t, input logic [5:0] m, input logic [5:0] act,
                     input logic p);
    if (tally < 3) tally++;
    u_rep.send(t, 3'h1, m);
    #1;
    chk("actions", {10'h0, retry, stage, att, det, bsw, msw}, {10'h0, act});
    @(posedge clk);
    #1;
    chk("retry after switch", {15'h0, retry}, {15'h0, act[1]});
    rd_reg("error log", `BIE_OFS_ERR_LOG, {t, 3'h1, m, p, tally[1:0]});
  endtask
  task automatic doinit(input logic [15:0] v, input logic withrep);
    init <= 1'b1;
    acd  <= v;
    repeat (4) @(posedge clk);
    if (withrep) u_rep.send(4'h8, 3'h1, SRC);
    repeat (2) @(posedge clk);
    init <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  task automatic give_verdict;
    $display("Comparisons %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ============================================================
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    give_verdict();
  end

  // ============================================================
  // Main sequence
  initial begin
    {rstn, wr, rd, init, addr, wdata} = '0;
    acd    = ACD;
    bus_id = BUS;
    num_errors = 0;
    check_count = 0;
    tally = 0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    doinit(ACD, 1'b0);
    wr_reg(`BIE_OFS_BUS_XCHG, 16'h0000);
    // Identity loads and fixed fields
    rd_reg("device type", `BIE_OFS_DEV_TYPE, {3'h0, BRD, PROC, 2'h0, DVER, 1'b1, DTYP});
    rd_reg("device id", `BIE_OFS_DEV_ID, {5'h0, BUS, 2'h0, MOD});
    rd_reg("logical_identity_register", `BIE_OFS_LOGICAL_IDENTITY_REGISTER, {10'h0, RMOD});
    chk("arb priority", {10'h0, arb}, {10'h0, RMOD});
    chk("participate id", {10'h0, part}, {10'h0, MOD});
    chk("backup bus", {13'h0, bkup}, {13'h0, BUS ^ 3'h2});
    b0 = bchk;
    @(posedge clk);
    #1;
    chk("buffer check toggles", {15'h0, bchk}, {15'h0, ~b0});
    // Read-only places and unmapped index
    wr_reg(`BIE_OFS_DEV_TYPE, 16'hFFFF);
    wr_reg(`BIE_OFS_DEV_ID, 16'hFFFF);
    wr_reg(`BIE_OFS_ERR_LOG, 16'hFFFF);
    rd_reg("device type kept", `BIE_OFS_DEV_TYPE, {3'h0, BRD, PROC, 2'h0, DVER, 1'b1, DTYP});
    rd_reg("device id kept", `BIE_OFS_DEV_ID, {5'h0, BUS, 2'h0, MOD});
    rd_reg("log kept", `BIE_OFS_ERR_LOG, 16'h0000);
    rd_reg("unmapped", 5'h07, 16'h0000);
    // First reports of every code but 4'h3 and 4'hD are transient
    wr_reg(`BIE_OFS_RCV_CTRL, 16'h0003);
    for (int c = 0; c < 16; c++) begin
      if (c != 3 && c != 13) rep(c[3:0], SRC, tact(c[3:0]), 1'b0);
    end
    // Repeats become permanent and switch; the last type code must age out first
    repeat (WIN + 4) @(posedge clk);
    foreach (pc[i]) begin
      rep(pc[i], SRC, tact(pc[i]), 1'b0);
      rep(pc[i], SRC, {4'h8, (pc[i] inside {4'hF, 4'hC, 4'h8, 4'hB, 4'h7}),
          (pc[i] inside {4'hE, 4'h9, 4'h6})}, 1'b1);
    end
    // Module switch held off by its enable, then let through by it
    wr_reg(`BIE_OFS_RCV_CTRL, 16'h0000);
    rep(4'hE, SRC, tact(4'hE), 1'b0);
    rep(4'hE, SRC, 6'h20, 1'b1);
    wr_reg(`BIE_OFS_RCV_CTRL, 16'h0002);
    rep(4'hD, 6'h11, 6'h21, 1'b1);
    // Judged against the last report only, and only in the window
    rep(4'h8, SRC, 6'h20, 1'b0);
    rep(4'h9, SRC, 6'h20, 1'b0);
    rep(4'h8, SRC, 6'h20, 1'b0);
    rep(4'h8, 6'h0B, 6'h20, 1'b0);
    repeat (WIN + 4) @(posedge clk);
    rep(4'h8, 6'h0B, 6'h20, 1'b0);
    // Interchange clears the tally
    wr_reg(`BIE_OFS_BUS_XCHG, 16'h0000);
    tally = 0;
    rep(4'h9, SRC, 6'h20, 1'b0);
    rep(4'h9, SRC, 6'h21, 1'b1);
    // Init clears tally and permanence, keeps the rest, ignores reports
    doinit(ACD, 1'b1);
    rd_reg("log after init", `BIE_OFS_ERR_LOG, {4'h9, 3'h1, SRC, 3'h0});
    // Logical identity write and shadowed participation
    wr_reg(`BIE_OFS_LOGICAL_IDENTITY_REGISTER, 16'hFF2A);
    rd_reg("logical written", `BIE_OFS_LOGICAL_IDENTITY_REGISTER, 16'h002A);
    chk("arb follows logical", {10'h0, arb}, 16'h002A);
    wr_reg(`BIE_OFS_RCV_CTRL, 16'h0004);
    #1;
    chk("shadow participation", {10'h0, part}, 16'h002A);
    // Bad module identity parity
    doinit(ACD ^ 16'h0002, 1'b0);
    chk("internal init held", {15'h0, iint}, 16'h0001);
    b0 = bchk;
    @(posedge clk);
    #1;
    chk("buffer check frozen", {15'h0, bchk}, {15'h0, b0});
    give_verdict();
  end
endmodule
